// ---- rtl/usf_pkg.sv ----
package usf_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_STATUS     = 8'h00;
  localparam logic [7:0]  OFS_CTRL_ONE   = 8'h04;
  localparam logic [7:0]  OFS_CTRL_TWO   = 8'h08;
  localparam logic [7:0]  OFS_DIVISOR    = 8'h0C;
  localparam logic [7:0]  OFS_TX_BUF     = 8'h10;
  localparam logic [7:0]  OFS_RX_BUF     = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned ST_TX_BUFFER_FULL_FLAG        = 0;
  localparam int unsigned ST_TX_BUSY_FLAG        = 1;
  localparam int unsigned ST_RX_BUFFER_FULL_FLAG        = 2;
  localparam int unsigned ST_PARITY_ERROR_FLAG        = 3;
  localparam int unsigned ST_FRAMING_ERROR_FLAG        = 4;
  localparam int unsigned ST_OVERRUN_FLAG        = 5;
  localparam int unsigned C1_TXE         = 0;
  localparam int unsigned C1_RXE         = 1;
  localparam int unsigned C1_STOP_BIT_COUNT_SEL        = 2;
  localparam int unsigned C1_PE          = 3;
  localparam int unsigned C1_ODD         = 4;
  localparam int unsigned C1_IRDA        = 5;
  localparam int unsigned C1_BRG_LO      = 6;
  localparam int unsigned C2_FILT_LO     = 3;

  // ---------------------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CTRL_ONE_RST   = 8'h00;
  localparam logic [7:0]  CTRL_TWO_RST   = 8'h00;
  localparam logic [7:0]  DIVISOR_RST    = 8'h00;
  localparam logic [4:0]  RT_SAMPLE_HI   = 5'h08;
  localparam logic [4:0]  RT_SAMPLE_LO   = 5'h06;
  localparam logic [3:0]  LAST_DATA_IDX  = 4'h8;
  localparam logic [3:0]  PARITY_IDX     = 4'h9;
  localparam logic [3:0]  BASE_LAST_IDX  = 4'h9;

  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_FRAME = 1'b1} usf_rx_state_t;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} usf_tx_state_t;

endpackage : usf_pkg

// ---- rtl/usf_uart.sv ----
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Receiver starts counting bit ticks on a falling receive edge while idle.
// - A received bit lasts 15, 16 or 17 ticks, counted down to zero.
// - Sample ticks eight, seven, six; the bit is the two-of-three majority.
// - Sampling ticks stay at eight to six for every bit length setting.
// - Start bit majority of one abandons the frame; next falling edge restarts.
// - Filter 00 off; 01, 10, 11 reject pulses under 1, 2, 4 tick periods.
// - Writing the transmit buffer sets full and sends the byte serially.
// - Frame is start, data, optional parity, then one or two stop bits.
// - Transmission start clears buffer full and raises a transmit request.
// - A second write before the load replaces the byte to be sent.
// - Transmit pin idles when disabled, before a first write, or in low power.
// - After the stop bits, data goes to the buffer, full set, receive request.
// - On overrun the new byte is dropped and the buffer stays unchanged.
// - Parity mismatch sets the parity error flag with a receive request.
// - Receive flags clear on buffer read only if seen set at the status read.
// - A buffer read that clears a parity error returns the received byte.
// - Stop bit sampled low sets the framing error flag with a receive request.
// - Data complete while the buffer is still full sets overrun with a request.
// - While overrun stays set, further frames are dropped with no request.
// - Dropped frames leave the parity and framing flags untouched.
// - Loading a received byte sets the receive buffer full flag.
// - Busy clears when a frame ends with nothing waiting; sets on restart.
// - The bit tick divides the selected base clock by divisor plus one.
module usf_uart (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [usf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Power state and requests
  input  wire logic                       low_power_req,
  output logic                            tx_irq,
  output logic                            rx_irq,
  // Serial lines
  input  wire logic                       serial_rx_pin,
  output logic                            serial_tx_pin
);
  import usf_pkg::*;

  // ---------------------------------------------------------------------------
  // Registers and bus access
  // ---------------------------------------------------------------------------
  logic [7:0]  ctrl_one_reg, ctrl_two_reg, divisor_reg, rx_holding_buffer, tx_holding_buffer;
  logic [31:0] prdata_reg;
  logic [5:0]  armed_reg;
  logic        tx_buffer_full_flag, tx_busy_flag, rx_buffer_full_flag;
  logic        parity_error_flag, framing_error_flag, overrun_flag;
  logic        acc, wr_acc, rd_acc, mapped, wr_tx, rd_rx, rd_st;
  logic [31:0] rd_mux;
  logic [5:0]  status_bits;

  assign status_bits = {overrun_flag, framing_error_flag, parity_error_flag,
                        rx_buffer_full_flag, tx_busy_flag, tx_buffer_full_flag};
  assign mapped  = paddr == OFS_STATUS || paddr == OFS_CTRL_ONE || paddr == OFS_CTRL_TWO ||
                   paddr == OFS_DIVISOR || paddr == OFS_TX_BUF || paddr == OFS_RX_BUF;
  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite && mapped;
  assign rd_acc  = acc && !pwrite && mapped;
  assign wr_tx   = wr_acc && paddr == OFS_TX_BUF;
  assign rd_rx   = rd_acc && paddr == OFS_RX_BUF;
  assign rd_st   = rd_acc && paddr == OFS_STATUS;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_reg;

  always_comb begin
    case (paddr)
      OFS_STATUS:   rd_mux = {26'h000_0000, status_bits};
      OFS_CTRL_ONE: rd_mux = {24'h00_0000, ctrl_one_reg};
      OFS_CTRL_TWO: rd_mux = {24'h00_0000, ctrl_two_reg};
      OFS_DIVISOR:  rd_mux = {24'h00_0000, divisor_reg};
      OFS_RX_BUF:   rd_mux = {24'h00_0000, rx_holding_buffer};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup cycle so that it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_reg <= CTRL_ONE_RST;
      ctrl_two_reg <= CTRL_TWO_RST;
      divisor_reg  <= DIVISOR_RST;
    end else if (wr_acc) begin
      if (paddr == OFS_CTRL_ONE) begin
        ctrl_one_reg <= pwdata[7:0];
      end
      if (paddr == OFS_CTRL_TWO) begin
        ctrl_two_reg <= pwdata[7:0];
      end
      if (paddr == OFS_DIVISOR) begin
        divisor_reg <= pwdata[7:0];
      end
    end
  end

  // Flags shown by the last status read arm their clear on the next buffer read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 6'h00;
    end else if (rd_st) begin
      armed_reg <= prdata_reg[5:0];
    end else if (rd_rx) begin
      armed_reg <= 6'h00;
    end
  end

  logic       txe, rx_enable_bit, stop_bit_count_sel, pe, odd, irda;
  logic [1:0] base_clock_sel, filt_sel;
  logic [2:0] rtsel;
  assign txe      = ctrl_one_reg[C1_TXE];
  assign rx_enable_bit      = ctrl_one_reg[C1_RXE];
  assign stop_bit_count_sel     = ctrl_one_reg[C1_STOP_BIT_COUNT_SEL];
  assign pe       = ctrl_one_reg[C1_PE];
  assign odd      = ctrl_one_reg[C1_ODD];
  assign irda     = ctrl_one_reg[C1_IRDA];
  assign base_clock_sel      = ctrl_one_reg[C1_BRG_LO +: 2];
  assign filt_sel = ctrl_two_reg[C2_FILT_LO +: 2];
  assign rtsel    = ctrl_two_reg[2:0];

  // ---------------------------------------------------------------------------
  // Bit tick generation
  // ---------------------------------------------------------------------------
  logic [2:0] pre_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic       base_en, bit_tick;

  // The base clock is pclk divided by 1, 2, 4 or 8 as the base clock select gives.
  assign base_en  = (pre_cnt_reg & ((3'h1 << base_clock_sel) - 3'h1)) == 3'h0;
  assign bit_tick = base_en && div_cnt_reg == divisor_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 3'h0;
      div_cnt_reg <= 8'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 3'h1;
      if (bit_tick) begin
        div_cnt_reg <= 8'h00;
      end else if (base_en) begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  // Last tick number of a bit; the alternating settings lengthen every odd bit.
  function automatic logic [4:0] rt_top(input logic [2:0] sel, input logic odd_bit);
    case (sel)
      3'h0:    rt_top = 5'h0F;
      3'h1:    rt_top = odd_bit ? 5'h10 : 5'h0F;
      3'h2:    rt_top = 5'h0E;
      3'h3:    rt_top = odd_bit ? 5'h0F : 5'h0E;
      3'h4:    rt_top = 5'h10;
      default: rt_top = 5'h0F;
    endcase
  endfunction : rt_top

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  // ---------------------------------------------------------------------------
  // Receive noise filter
  // ---------------------------------------------------------------------------
  logic       rx_in, rx_filt_reg, rx_prev_reg;
  logic [2:0] filt_cnt_reg, filt_len;
  assign rx_in    = serial_rx_pin ^ irda;
  assign filt_len = 3'h1 << (filt_sel - 2'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_filt_reg  <= 1'b1;
      filt_cnt_reg <= 3'h0;
    end else if (filt_sel == 2'h0) begin
      rx_filt_reg  <= rx_in;
      filt_cnt_reg <= 3'h0;
    end else if (rx_in == rx_filt_reg) begin
      filt_cnt_reg <= 3'h0;
    end else if (bit_tick) begin
      if (filt_cnt_reg + 3'h1 == filt_len) begin
        rx_filt_reg  <= rx_in;
        filt_cnt_reg <= 3'h0;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  usf_rx_state_t rx_state_reg;
  logic [4:0] rx_rt_reg;
  logic [3:0] rx_idx_reg, last_idx;
  logic [2:0] rx_samp_reg;
  logic [7:0] rx_data_reg;
  logic       rx_fe_reg, rx_pbad_reg, rx_drop_reg, rx_fall, rx_bit_end, rx_bit, samp_we;
  logic       rx_store, ovr_set, rx_irq_reg;

  assign last_idx   = BASE_LAST_IDX + {3'h0, pe} + {3'h0, stop_bit_count_sel};
  assign rx_fall    = rx_prev_reg && !rx_filt_reg;
  assign rx_bit_end = rx_state_reg == RX_FRAME && bit_tick && rx_rt_reg == 5'h00;
  assign rx_bit     = majority(rx_samp_reg);
  assign samp_we    = rx_state_reg == RX_FRAME && bit_tick &&
                      rx_rt_reg >= RT_SAMPLE_LO && rx_rt_reg <= RT_SAMPLE_HI;
  assign ovr_set    = rx_bit_end && rx_idx_reg == LAST_DATA_IDX && rx_buffer_full_flag;
  assign rx_store   = rx_bit_end && rx_idx_reg == last_idx && !rx_drop_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_filt_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= RX_IDLE;
      rx_rt_reg    <= 5'h00;
      rx_idx_reg   <= 4'h0;
      rx_samp_reg  <= 3'h7;
      rx_data_reg  <= 8'h00;
      rx_fe_reg    <= 1'b0;
      rx_pbad_reg  <= 1'b0;
      rx_drop_reg  <= 1'b0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_enable_bit && rx_fall) begin
            rx_state_reg <= RX_FRAME;
            rx_rt_reg    <= rt_top(rtsel, 1'b0);
            rx_idx_reg   <= 4'h0;
            rx_fe_reg    <= 1'b0;
            rx_pbad_reg  <= 1'b0;
            rx_drop_reg  <= 1'b0;
          end
        end
        RX_FRAME: begin
          if (!rx_enable_bit) begin
            rx_state_reg <= RX_IDLE;
          end else if (samp_we) begin
            rx_samp_reg[rx_rt_reg[1:0] - 2'h2] <= rx_filt_reg;
            rx_rt_reg <= rx_rt_reg - 5'h01;
          end else if (rx_bit_end) begin
            rx_rt_reg  <= rt_top(rtsel, ~rx_idx_reg[0]);
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0 && rx_bit) begin
              rx_state_reg <= RX_IDLE;
            end else if (rx_idx_reg <= LAST_DATA_IDX && rx_idx_reg != 4'h0) begin
              rx_data_reg <= {rx_bit, rx_data_reg[7:1]};
            end else if (pe && rx_idx_reg == PARITY_IDX) begin
              rx_pbad_reg <= rx_bit != (^rx_data_reg ^ odd);
            end else if (!rx_bit && rx_idx_reg != 4'h0) begin
              rx_fe_reg <= 1'b1;
            end
            if (ovr_set || (rx_idx_reg == LAST_DATA_IDX && overrun_flag)) begin
              rx_drop_reg <= 1'b1;
            end
            if (rx_idx_reg == last_idx) begin
              rx_state_reg <= RX_IDLE;
            end
          end else if (bit_tick) begin
            rx_rt_reg <= rx_rt_reg - 5'h01;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  logic parity_error_flag_set, framing_error_flag_set;
  assign parity_error_flag_set = rx_store && (rx_pbad_reg || (pe && rx_idx_reg == PARITY_IDX &&
                    rx_bit != (^rx_data_reg ^ odd)));
  assign framing_error_flag_set = rx_store && (rx_fe_reg || !rx_bit);

  // Hardware sets win over a clearing buffer read in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding_buffer   <= 8'h00;
      rx_buffer_full_flag <= 1'b0;
      parity_error_flag   <= 1'b0;
      framing_error_flag  <= 1'b0;
      overrun_flag        <= 1'b0;
      rx_irq_reg          <= 1'b0;
    end else begin
      rx_irq_reg <= rx_store || (ovr_set && !overrun_flag);
      if (rx_store) begin
        rx_holding_buffer <= rx_data_reg;
      end
      if (rx_store) begin
        rx_buffer_full_flag <= 1'b1;
      end else if (rd_rx && armed_reg[ST_RX_BUFFER_FULL_FLAG]) begin
        rx_buffer_full_flag <= 1'b0;
      end
      if (parity_error_flag_set) begin
        parity_error_flag <= 1'b1;
      end else if (rd_rx && armed_reg[ST_PARITY_ERROR_FLAG]) begin
        parity_error_flag <= 1'b0;
      end
      if (framing_error_flag_set) begin
        framing_error_flag <= 1'b1;
      end else if (rd_rx && armed_reg[ST_FRAMING_ERROR_FLAG]) begin
        framing_error_flag <= 1'b0;
      end
      if (ovr_set) begin
        overrun_flag <= 1'b1;
      end else if (rd_rx && armed_reg[ST_OVERRUN_FLAG]) begin
        overrun_flag <= 1'b0;
      end
    end
  end
  assign rx_irq = rx_irq_reg;

  // ---------------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------------
  usf_tx_state_t tx_state_reg;
  logic [4:0]  tx_rt_reg;
  logic [3:0]  tx_idx_reg;
  logic [11:0] tx_shift_reg;
  logic        tx_end, tx_load, tx_irq_reg, tx_pin_reg;

  assign tx_end  = tx_state_reg == TX_SEND && bit_tick && tx_rt_reg == 5'h00 &&
                   tx_idx_reg == last_idx;
  assign tx_load = txe && !low_power_req && tx_buffer_full_flag &&
                   (tx_state_reg == TX_IDLE || tx_end);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_buffer   <= 8'h00;
      tx_buffer_full_flag <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_holding_buffer <= pwdata[7:0];
      end
      if (wr_tx) begin
        tx_buffer_full_flag <= 1'b1;
      end else if (tx_load) begin
        tx_buffer_full_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= TX_IDLE;
      tx_rt_reg    <= 5'h00;
      tx_idx_reg   <= 4'h0;
      tx_shift_reg <= 12'hFFF;
      tx_busy_flag <= 1'b0;
      tx_irq_reg   <= 1'b0;
    end else begin
      tx_irq_reg <= tx_load;
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_load) begin
            tx_state_reg <= TX_SEND;
            tx_busy_flag <= 1'b1;
          end
        end
        TX_SEND: begin
          if (!txe) begin
            tx_state_reg <= TX_IDLE;
            tx_busy_flag <= 1'b0;
          end else if (tx_end && !tx_load) begin
            tx_state_reg <= TX_IDLE;
            tx_busy_flag <= 1'b0;
          end else if (bit_tick && tx_rt_reg == 5'h00 && !tx_end) begin
            tx_rt_reg    <= rt_top(rtsel, ~tx_idx_reg[0]);
            tx_idx_reg   <= tx_idx_reg + 4'h1;
            tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
          end else if (bit_tick && tx_rt_reg != 5'h00) begin
            tx_rt_reg <= tx_rt_reg - 5'h01;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
      if (tx_load) begin
        tx_rt_reg    <= rt_top(rtsel, 1'b0);
        tx_idx_reg   <= 4'h0;
        tx_shift_reg <= pe ? {2'b11, ^tx_holding_buffer ^ odd, tx_holding_buffer, 1'b0}
                           : {3'b111, tx_holding_buffer, 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_reg <= 1'b1;
    end else if (!txe || low_power_req || tx_state_reg != TX_SEND) begin
      tx_pin_reg <= !irda;
    end else begin
      tx_pin_reg <= tx_shift_reg[0] ^ irda;
    end
  end
  assign serial_tx_pin = tx_pin_reg;
  assign tx_irq        = tx_irq_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rx_start_count: assert property (rx_state_reg == RX_IDLE && rx_enable_bit && rx_fall |=>
    rx_state_reg == RX_FRAME && rx_idx_reg == 4'h0 && rx_rt_reg >= 5'h0E)
    else $error("receiver did not start counting on falling edge");
  a_rt_bound: assert property (rx_state_reg == RX_FRAME |-> rx_rt_reg <= 5'h10)
    else $error("bit tick count above sixteen");
  a_sample_ticks: assert property (samp_we && rx_enable_bit && rx_rt_reg == RT_SAMPLE_HI |=>
    rx_samp_reg[2] == $past(rx_filt_reg)) else $error("first majority sample not stored");
  a_start_abort: assert property (rx_bit_end && rx_idx_reg == 4'h0 && rx_bit |=>
    rx_state_reg == RX_IDLE && !rx_irq_reg) else $error("false start bit not abandoned");
  a_txbuf_full: assert property (wr_tx |=> tx_buffer_full_flag)
    else $error("transmit buffer write did not set full flag");
  a_tx_start_irq: assert property (tx_load |=> tx_irq && tx_busy_flag && tx_idx_reg == 4'h0
    ##1 !tx_irq) else $error("transmit start without one-cycle request");
  a_tx_idle_pin: assert property (!txe || low_power_req |=> serial_tx_pin == !$past(irda))
    else $error("transmit pin not at idle level");
  a_rx_store_flag: assert property (rx_store |=> rx_buffer_full_flag && rx_irq
    && rx_holding_buffer == $past(rx_data_reg)) else $error("received byte not stored");
  a_ovr_keep: assert property (overrun_flag && rx_bit_end |=> $stable(rx_holding_buffer))
    else $error("receive buffer changed during overrun");
  a_flag_hold: assert property (rd_rx && !armed_reg[ST_RX_BUFFER_FULL_FLAG] && rx_buffer_full_flag
    |=> rx_buffer_full_flag) else $error("unarmed full flag cleared");
  a_ovr_quiet: assert property (overrun_flag && rx_bit_end && rx_idx_reg == last_idx
    |=> !rx_irq) else $error("request raised for dropped frame");

  c_rx_frame: cover property (rx_store);
  c_overrun: cover property (ovr_set);
  c_parity_err: cover property (parity_error_flag_set);
  c_tx_chain: cover property (tx_end && tx_load);

endmodule : usf_uart

// ---- verif/uart_sampling_txrx_flags_test.sv ----
`timescale 1ns/100ps
module uart_sampling_txrx_flags_test;
  import usf_pkg::*;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic              low_power_req = 0, pready, pslverr, tx_irq, rx_irq, err, stp;
  logic              serial_rx_pin, serial_tx_pin;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic [7:0]        byt;
  int                fails = 0, total_checks = 0, tx_cnt = 0, rx_cnt = 0, n;

  usf_uart i_usf_uart (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_req(low_power_req), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin));
  usf_remote_model i_usf_remote_model (.pclk(pclk), .serial_tx_pin(serial_tx_pin),
    .serial_rx_pin(serial_rx_pin));

  // ---------------------------------------------------------------------------
  // Clock, pulse counters and helpers
  // ---------------------------------------------------------------------------
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (tx_irq === 1'b1) tx_cnt <= tx_cnt + 1;
    if (rx_irq === 1'b1) rx_cnt <= rx_cnt + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_tx();
    apb(1, OFS_CTRL_ONE, 32'h0000_0003);
    check(serial_tx_pin, 1'b1);
    n = tx_cnt;
    fork
      i_usf_remote_model.recv_frame(byt, stp);
      begin
        apb(1, OFS_TX_BUF, 32'h0000_00A5);
        apb(1, OFS_TX_BUF, 32'h0000_005A);
        apb(1, OFS_TX_BUF, 32'h0000_00C3);
      end
    join
    check(byt, 8'hA5);
    check(stp, 1'b1);
    i_usf_remote_model.recv_frame(byt, stp);
    check(byt, 8'hC3);
    repeat (20) @(posedge pclk);
    check(tx_cnt - n, 2);
    low_power_req <= 1'b1;
    apb(1, OFS_TX_BUF, 32'h0000_0077);
    repeat (20) @(posedge pclk);
    check(serial_tx_pin, 1'b1);
    apb(0, OFS_STATUS, 0);
    check(rd, 32'h0000_0001);
    low_power_req <= 1'b0;
    i_usf_remote_model.recv_frame(byt, stp);
    check(byt, 8'h77);
    repeat (20) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    check(rd, 32'h0000_0000);
    $display("test tx done");
  endtask : t_tx

  // Sends one frame and reads status, expecting the given flags.
  task automatic rx_one(input logic [7:0] d, input logic pe, input logic par,
                        input logic stop, input logic [31:0] st);
    i_usf_remote_model.send_frame(d, pe, par, stop);
    repeat (4) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    check(rd, st);
  endtask : rx_one

  task automatic t_rx();
    apb(0, OFS_STATUS, 0);
    n = rx_cnt;
    i_usf_remote_model.glitch();
    check(rx_cnt - n, 0);
    i_usf_remote_model.send_frame(8'h3C, 0, 0, 1);
    repeat (4) @(posedge pclk);
    apb(0, OFS_RX_BUF, 0);
    check(rx_cnt - n, 1);
    rx_one(8'h11, 0, 0, 1, 32'h0000_0024);
    rx_one(8'h22, 0, 0, 1, 32'h0000_0024);
    check(rx_cnt - n, 2);
    apb(0, OFS_RX_BUF, 0);
    check(rd, 32'h0000_003C);
    apb(0, OFS_STATUS, 0);
    check(rd, 32'h0000_0000);
    rx_one(8'h5A, 0, 0, 0, 32'h0000_0014);
    apb(0, OFS_RX_BUF, 0);
    check(rd, 32'h0000_005A);
    apb(1, OFS_CTRL_ONE, 32'h0000_000B);
    rx_one(8'h3C, 1, 1, 1, 32'h0000_000C);
    apb(0, OFS_RX_BUF, 0);
    rx_one(8'h3C, 1, 0, 1, 32'h0000_0004);
    apb(0, 8'h40, 0);
    check(err, 1'b1);
    apb(0, OFS_RX_BUF, 0);
    apb(1, OFS_CTRL_TWO, 32'h0000_0018);
    n = rx_cnt;
    i_usf_remote_model.glitch();
    rx_one(8'h96, 1, 0, 1, 32'h0000_0004);
    apb(0, OFS_RX_BUF, 0);
    check(rd, 32'h0000_0096);
    check(rx_cnt - n, 1);
    $display("test rx done");
  endtask : t_rx

  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    $display("[FAIL] %0t timeout", $time);
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_STATUS, 0);
    check(rd, 32'h0000_0000);
    t_tx();
    t_rx();
    print_verdict();
  end
endmodule : uart_sampling_txrx_flags_test

// ---- verif/usf_remote_model.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Remote serial device, 16 clocks a bit
// ---------------------------------------------------------------------------
module usf_remote_model (
  // Clock
  input  wire logic pclk,
  // Serial lines
  input  wire logic serial_tx_pin,
  output logic      serial_rx_pin
);
  initial serial_rx_pin = 1'b1;

  task automatic send_frame(input logic [7:0] d, input logic pe, input logic par,
                            input logic stop);
    logic [10:0] f;
    f = {stop, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || pe) begin
        @(posedge pclk) serial_rx_pin <= f[i];
        repeat (15) @(posedge pclk);
      end
    end
    @(posedge pclk) serial_rx_pin <= 1'b1;
  endtask : send_frame

  // A low pulse far shorter than half a bit, seen as noise on a start bit.
  task automatic glitch();
    @(posedge pclk) serial_rx_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    serial_rx_pin <= 1'b1;
    repeat (40) @(posedge pclk);
  endtask : glitch

  task automatic recv_frame(output logic [7:0] d, output logic stop);
    int n;
    n = 0;
    while (serial_tx_pin !== 1'b0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge pclk);
      d[i] = serial_tx_pin;
    end
    repeat (16) @(posedge pclk);
    stop = serial_tx_pin;
  endtask : recv_frame
endmodule : usf_remote_model
